// File: hdl/i2cm_ctrl.sv
// Host controller top: drives a three-space serial slave over SCL and SDA
// Assumes open-drain wires resolved outside from the *_oe outputs, pull-ups high
// Operation
// - 7-bit address plus direction, 1 means read
// - Receiver pulls SDA low on ninth pulse
// - Write sends address bytes then data burst
// - Write bytes acked; STOP or Sr ends
// - Random read: address-only write, then read
// - Host acks reads, NACKs last byte
// - SDA changes only while SCL is low
// - START and STOP are SDA edges, SCL high
// - Bytes of eight bits, MSB first, acked
// - Missing ack is NACK, operation aborts
// - Device NACKs bad or protected writes
// - Master code 0000_1xxx, unacked, enters high speed
// - Memory uses two address bytes, MSB zero
// - Clock registers take one address byte
`timescale 1ns/1ns
`default_nettype none
`include "i2cm_regs.svh"
module i2cm_ctrl
  import i2cm_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire logic                    cmd_rw,
  input  wire logic [1:0]              cmd_space,
  input  wire logic [2:0]              cmd_dev_sel,
  input  wire logic                    cmd_use_addr,
  input  wire logic [`I2CM_ADDR_W-1:0] cmd_addr,
  input  wire logic [7:0]              cmd_len,
  input  wire logic                    cmd_hs,
  input  wire logic                    cmd_stop,
  input  wire logic                    wr_valid,
  output logic                         wr_ready,
  input  wire logic [7:0]              wr_data,
  output logic                         rd_valid,
  output logic      [7:0]              rd_data,
  output logic                         done,
  output logic                         nack_err,
  output logic                         bus_busy,
  output logic                         hs_active,
  output logic      [`I2CM_ADDR_W-1:0] cur_addr,
  input  wire logic                    scl_i,
  output logic                         scl_o,
  output logic                         scl_oe,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe
);
  // ****************************************
  // State
  // ****************************************
  i2cm_state_e             st;
  i2cm_step_e              step;
  logic [3:0]              bitcnt;
  logic [7:0]              shreg;
  logic [7:0]              remaining;
  logic                    wait_bit;
  logic                    go;
  i2cm_op_e                go_op;
  logic                    go_bit;
  logic                    rw_q;
  i2cm_space_e             space_q;
  logic [2:0]              dev_q;
  logic                    use_addr_q;
  logic [`I2CM_ADDR_W-1:0] addr_q;
  logic                    stop_q;
  logic                    hs_req_q;
  logic                    bit_done;
  logic                    bit_rx;
  logic                    scl_s;
  logic                    sda_s;
  logic                    cmd_take;
  logic                    wr_take;
  logic                    ninth;
  logic                    ack_ok;
  logic                    addr_step;
  i2cm_state_e             fin_st;
  i2cm_step_e              sel_step;

  assign cmd_take  = cmd_valid && cmd_ready;
  assign wr_take   = wr_valid && wr_ready;
  assign ninth     = bit_done && bitcnt == `I2CM_ACK_BIT;
  assign ack_ok    = ninth && st == ST_TX && !bit_rx;
  assign fin_st    = stop_q ? ST_STOP : ST_HELD;
  assign sel_step  = (rw_q && !use_addr_q) ? STEP_SEL_R : STEP_SEL_W;
  // Shadow of the device pointer: in memory space, every acked write byte and every read byte moves it on
  assign addr_step = space_q == SPACE_MEM
                     && ((ack_ok && step == STEP_DATA) || (ninth && st == ST_RX));

  function automatic logic [3:0] space_code(i2cm_space_e s);
    unique case (s)
      SPACE_MEM:  return `I2CM_CODE_MEM;
      SPACE_RTC:  return `I2CM_CODE_RTC;
      default:    return `I2CM_CODE_CTRL;
    endcase
  endfunction

  // Byte to shift out at the start of each addressing step
  function automatic logic [7:0] byte_for(i2cm_step_e s);
    unique case (s)
      STEP_MCODE:   return `I2CM_MCODE;
      STEP_SEL_W:   return {space_code(space_q), dev_q, 1'b0};
      STEP_SEL_R:   return {space_code(space_q), dev_q, 1'b1};
      STEP_ADDR_HI: return {1'b0, addr_q[14:8]};
      default:      return addr_q[7:0];
    endcase
  endfunction

  // ****************************************
  // Pins
  // ****************************************
  i2cm_sync #(
    .W(2)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .pin_in   ({scl_i, sda_i}),
    .pin_sync ({scl_s, sda_s})
  );

  i2cm_bit u_bit (
    .clk    (clk),
    .rst    (rst),
    .hs     (hs_active),
    .go     (go),
    .op     (go_op),
    .bit_tx (go_bit),
    .scl_in (scl_s),
    .sda_in (sda_s),
    .done   (bit_done),
    .bit_rx (bit_rx),
    .scl_oe (scl_oe),
    .sda_oe (sda_oe)
  );

  // Open-drain pins only ever pull low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // ****************************************
  // Command latch
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rw_q       <= 1'b0;
      space_q    <= SPACE_MEM;
      dev_q      <= 3'h0;
      use_addr_q <= 1'b0;
      addr_q     <= `I2CM_RST_ADDR;
      stop_q     <= 1'b1;
      hs_req_q   <= 1'b0;
    end else if (cmd_take) begin
      rw_q       <= cmd_rw;
      space_q    <= i2cm_space_e'(cmd_space);
      dev_q      <= cmd_dev_sel;
      use_addr_q <= cmd_use_addr;
      addr_q     <= cmd_addr;
      stop_q     <= cmd_stop;
      hs_req_q   <= cmd_hs;
    end
  end

  // ****************************************
  // Byte sequencer
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st        <= ST_IDLE;
      step      <= STEP_SEL_W;
      bitcnt    <= 4'h0;
      shreg     <= `I2CM_RST_BYTE;
      remaining <= 8'h00;
      wait_bit  <= 1'b0;
      go        <= 1'b0;
      go_op     <= OP_STOP;
      go_bit    <= 1'b1;
      cmd_ready <= 1'b1;
      wr_ready  <= 1'b0;
      done      <= 1'b0;
      nack_err  <= 1'b0;
    end else begin
      go   <= 1'b0;
      done <= 1'b0;
      unique case (st)
        ST_IDLE, ST_HELD: begin
          if (cmd_take) begin
            cmd_ready <= 1'b0;
            nack_err  <= 1'b0;
            // A read always fetches at least one byte
            remaining <= (cmd_rw && cmd_len == 8'h00) ? 8'h01 : cmd_len;
            if (cmd_hs && !hs_active) begin
              step <= STEP_MCODE;
            end else begin
              step <= (cmd_rw && !cmd_use_addr) ? STEP_SEL_R : STEP_SEL_W;
            end
            st <= ST_START;
          end
        end
        ST_START, ST_STOP: begin
          if (!wait_bit) begin
            go       <= 1'b1;
            wait_bit <= 1'b1;
            go_op    <= (st == ST_START) ? OP_START : OP_STOP;
          end else if (bit_done) begin
            wait_bit <= 1'b0;
            if (st == ST_START) begin
              st     <= ST_TX;
              bitcnt <= 4'h0;
              shreg  <= byte_for(step);
            end else begin
              st        <= ST_IDLE;
              cmd_ready <= 1'b1;
              done      <= 1'b1;
            end
          end
        end
        ST_WAIT_WR: begin
          if (wr_take) begin
            wr_ready <= 1'b0;
            shreg    <= wr_data;
            bitcnt   <= 4'h0;
            st       <= ST_TX;
          end
        end
        ST_TX: begin
          if (!wait_bit) begin
            go       <= 1'b1;
            wait_bit <= 1'b1;
            // Ninth pulse: let go of SDA and listen for the ack
            go_op    <= (bitcnt == `I2CM_ACK_BIT) ? OP_READ : OP_WRITE;
            go_bit   <= (bitcnt == `I2CM_ACK_BIT) ? 1'b1 : shreg[7];
          end else if (bit_done) begin
            wait_bit <= 1'b0;
            if (bitcnt != `I2CM_ACK_BIT) begin
              bitcnt <= bitcnt + 4'h1;
              shreg  <= {shreg[6:0], 1'b0};
            end else begin
              bitcnt <= 4'h0;
              if (step == STEP_MCODE) begin
                // Master code goes unacked by design; follow with Sr
                step  <= sel_step;
                shreg <= byte_for(sel_step);
                st    <= ST_START;
              end else if (bit_rx) begin
                nack_err <= 1'b1;
                st       <= ST_STOP;
              end else begin
                unique case (step)
                  STEP_SEL_W: begin
                    if (use_addr_q) begin
                      step  <= (space_q == SPACE_MEM) ? STEP_ADDR_HI : STEP_ADDR_LO;
                      shreg <= byte_for((space_q == SPACE_MEM) ? STEP_ADDR_HI : STEP_ADDR_LO);
                    end else if (remaining == 8'h00) begin
                      st        <= fin_st;
                      cmd_ready <= !stop_q;
                      done      <= !stop_q;
                    end else begin
                      step     <= STEP_DATA;
                      st       <= ST_WAIT_WR;
                      wr_ready <= 1'b1;
                    end
                  end
                  STEP_ADDR_HI: begin
                    step  <= STEP_ADDR_LO;
                    shreg <= byte_for(STEP_ADDR_LO);
                  end
                  STEP_SEL_R: begin
                    st <= ST_RX;
                  end
                  default: begin
                    if (step == STEP_ADDR_LO && rw_q) begin
                      // Address only, no data: Sr then read from there
                      step  <= STEP_SEL_R;
                      shreg <= byte_for(STEP_SEL_R);
                      st    <= ST_START;
                    end else if (remaining == 8'h00 || (step == STEP_DATA && remaining == 8'h01)) begin
                      st        <= fin_st;
                      cmd_ready <= !stop_q;
                      done      <= !stop_q;
                      remaining <= 8'h00;
                    end else begin
                      if (step == STEP_DATA) begin
                        remaining <= remaining - 8'h01;
                      end
                      step     <= STEP_DATA;
                      st       <= ST_WAIT_WR;
                      wr_ready <= 1'b1;
                    end
                  end
                endcase
              end
            end
          end
        end
        ST_RX: begin
          if (!wait_bit) begin
            go       <= 1'b1;
            wait_bit <= 1'b1;
            go_op    <= (bitcnt == `I2CM_ACK_BIT) ? OP_WRITE : OP_READ;
            // Ack every byte but the last, which gets a NACK
            go_bit   <= (bitcnt == `I2CM_ACK_BIT) ? (remaining == 8'h01) : 1'b1;
          end else if (bit_done) begin
            wait_bit <= 1'b0;
            if (bitcnt != `I2CM_ACK_BIT) begin
              bitcnt <= bitcnt + 4'h1;
              shreg  <= {shreg[6:0], bit_rx};
            end else begin
              bitcnt    <= 4'h0;
              remaining <= remaining - 8'h01;
              if (remaining == 8'h01) begin
                st        <= fin_st;
                cmd_ready <= !stop_q;
                done      <= !stop_q;
              end
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Read data, bus, speed and address status
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= `I2CM_RST_BYTE;
    end else begin
      rd_valid <= st == ST_RX && bit_done && bitcnt == `I2CM_LAST_BIT;
      if (st == ST_RX && bit_done && bitcnt == `I2CM_LAST_BIT) begin
        rd_data <= {shreg[6:0], bit_rx};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_busy <= 1'b0;
    end else if (st == ST_STOP && bit_done) begin
      bus_busy <= 1'b0;
    end else if (st == ST_START && bit_done) begin
      bus_busy <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_active <= 1'b0;
    end else if (st == ST_STOP && bit_done) begin
      hs_active <= 1'b0;
    end else if (st == ST_TX && step == STEP_MCODE && ninth && hs_req_q) begin
      hs_active <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_addr <= `I2CM_RST_ADDR;
    end else if (cmd_take && cmd_use_addr && cmd_space == 2'h0) begin
      cur_addr <= cmd_addr;
    end else if (addr_step) begin
      cur_addr <= cur_addr + `I2CM_ADDR_W'(1);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sel_write:
    assert property (st == ST_TX && step == STEP_SEL_W && bitcnt == 4'h0
                     |-> shreg == {space_code(space_q), dev_q, 1'b0})
    else $error("write select byte wrong");
  a_sel_read:
    assert property (st == ST_TX && step == STEP_SEL_R && bitcnt == 4'h0 |-> shreg[0] && shreg[3:1] == dev_q)
    else $error("read select byte wrong");
  a_addr_msb:
    assert property (st == ST_TX && step == STEP_ADDR_HI && bitcnt == 4'h0 |-> !shreg[7])
    else $error("high address byte MSB not zero");
  a_msb_first:
    assert property (go && st == ST_TX && go_op == OP_WRITE |-> go_bit == shreg[7] && bitcnt < 4'h8)
    else $error("bit order wrong");
  a_last_nack:
    assert property (go && st == ST_RX && bitcnt == `I2CM_ACK_BIT
                     |-> go_op == OP_WRITE && go_bit == (remaining == 8'h01))
    else $error("read ack level wrong");
  a_nack_abort:
    assert property (ninth && st == ST_TX && bit_rx && step != STEP_MCODE |=> st == ST_STOP && nack_err)
    else $error("NACK did not abort");
  a_rand_read:
    assert property (ack_ok && step == STEP_ADDR_LO && rw_q |=> st == ST_START && step == STEP_SEL_R)
    else $error("random read did not restart");
  a_hs_entry:
    assert property (ninth && st == ST_TX && step == STEP_MCODE |=> hs_active && st == ST_START)
    else $error("high speed not entered");
  a_hs_keep:
    assert property (hs_active && !(st == ST_STOP && bit_done) |=> hs_active)
    else $error("high speed left without STOP");
  a_busy_free:
    assert property (st == ST_STOP && bit_done |=> !bus_busy && cmd_ready && done && !hs_active)
    else $error("bus not freed at STOP");
  a_addr_wrap:
    assert property (addr_step && cur_addr == `I2CM_TOP_ADDR |=> cur_addr == `I2CM_RST_ADDR)
    else $error("address did not wrap");

  c_write_done: cover property (ack_ok && step == STEP_DATA ##[1:1000] done);
  c_read_byte:  cover property (rd_valid);
  c_hs_entry:   cover property ($rose(hs_active));
  c_nack:       cover property ($rose(nack_err));
endmodule
`default_nettype wire

// File: shared/i2cm_regs.svh
// Constants for the i2c host controller: timing counts and byte codes
// Assumes inclusion by bare name from design files; definitions only
`ifndef I2CM_REGS_SVH
`define I2CM_REGS_SVH

// ****************************************
// Timing
// ****************************************
`define I2CM_CLK_KHZ      20000
`define I2CM_FS_KHZ       100
`define I2CM_HS_KHZ       3400
`define I2CM_QTR_W        6
// Quarter bit periods, rounded up so SCL never runs faster than asked
`define I2CM_FS_QTR_CYC   ((`I2CM_CLK_KHZ + 4 * `I2CM_FS_KHZ - 1) / (4 * `I2CM_FS_KHZ))
`define I2CM_HS_QTR_CYC   ((`I2CM_CLK_KHZ + 4 * `I2CM_HS_KHZ - 1) / (4 * `I2CM_HS_KHZ))

// ****************************************
// Byte codes and positions
// ****************************************
`define I2CM_CODE_MEM     4'ha
`define I2CM_CODE_RTC     4'hd
`define I2CM_CODE_CTRL    4'h3
`define I2CM_MCODE        8'h08
`define I2CM_ADDR_W       15
`define I2CM_ACK_BIT      4'h8
`define I2CM_LAST_BIT     4'h7
`define I2CM_RST_BYTE     8'h00
`define I2CM_RST_ADDR     15'h0000
`define I2CM_TOP_ADDR     15'h7fff
`endif

// File: shared/i2cm_pkg.sv
// Types shared by the i2c host controller modules
// Assumes nothing of its surroundings
`default_nettype none
package i2cm_pkg;
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} i2cm_op_e;
  typedef enum logic [1:0] {SPACE_MEM, SPACE_RTC, SPACE_CTRL} i2cm_space_e;
  typedef enum {ST_IDLE, ST_HELD, ST_START, ST_TX, ST_RX, ST_WAIT_WR, ST_STOP} i2cm_state_e;
  typedef enum {STEP_MCODE, STEP_SEL_W, STEP_ADDR_HI, STEP_ADDR_LO, STEP_DATA, STEP_SEL_R} i2cm_step_e;
endpackage
`default_nettype wire

// File: hdl/i2cm_sync.sv
// Two flip-flop synchronisers for the bus pins
// Assumes pins idle high through pull-ups
`timescale 1ns/1ns
`default_nettype none
module i2cm_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);
  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta;
      logic sync_q;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta   <= 1'b1;
          sync_q <= 1'b1;
        end else begin
          meta   <= pin_in[i];
          sync_q <= meta;
        end
      end
      assign pin_sync[i] = sync_q;
    end
  endgenerate
endmodule
`default_nettype wire

// File: hdl/i2cm_bit.sv
// Bit engine: one START, STOP, write bit or read bit in four quarter phases
// Assumes synchronised pin inputs; go is ignored while a bit is running
`timescale 1ns/1ns
`default_nettype none
`include "i2cm_regs.svh"
module i2cm_bit
  import i2cm_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     hs,
  input  wire logic     go,
  input  wire i2cm_op_e op,
  input  wire logic     bit_tx,
  input  wire logic     scl_in,
  input  wire logic     sda_in,
  output logic          done,
  output logic          bit_rx,
  output logic          scl_oe,
  output logic          sda_oe
);
  logic                   active;
  i2cm_op_e               op_q;
  logic                   bit_q;
  logic [1:0]             phase;
  logic [`I2CM_QTR_W-1:0] qcnt;
  logic [`I2CM_QTR_W-1:0] qmax;
  logic                   stall;
  logic                   qend;

  // Phase 0, and phase 3 except in a STOP, hold SCL low; write and read data only move there
  function automatic logic [1:0] pins(i2cm_op_e o, logic [1:0] p, logic b);
    logic scl_low;
    logic sda_low;
    scl_low = (p == 2'h0) || (p == 2'h3 && o != OP_STOP);
    unique case (o)
      OP_START: sda_low = p[1];
      OP_STOP:  sda_low = !p[1];
      OP_WRITE: sda_low = !b;
      OP_READ:  sda_low = 1'b0;
    endcase
    return {scl_low, sda_low};
  endfunction

  assign qmax  = hs ? `I2CM_QTR_W'(`I2CM_HS_QTR_CYC - 1) : `I2CM_QTR_W'(`I2CM_FS_QTR_CYC - 1);
  // Released SCL still low: wait, so the high time is never cut short
  assign stall = !scl_oe && !scl_in;
  assign qend  = active && !stall && (qcnt == qmax);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active <= 1'b0;
      op_q   <= OP_STOP;
      bit_q  <= 1'b1;
      phase  <= 2'h0;
      qcnt   <= {`I2CM_QTR_W{1'b0}};
    end else if (go && !active) begin
      active <= 1'b1;
      op_q   <= op;
      bit_q  <= bit_tx;
      phase  <= 2'h0;
      qcnt   <= {`I2CM_QTR_W{1'b0}};
    end else if (qend) begin
      qcnt   <= {`I2CM_QTR_W{1'b0}};
      phase  <= phase + 2'h1;
      active <= (phase != 2'h3);
    end else if (active && !stall) begin
      qcnt   <= qcnt + `I2CM_QTR_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (go && !active) begin
      {scl_oe, sda_oe} <= pins(op, 2'h0, bit_tx);
    end else if (qend && phase != 2'h3) begin
      {scl_oe, sda_oe} <= pins(op_q, phase + 2'h1, bit_q);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done   <= 1'b0;
      bit_rx <= 1'b1;
    end else begin
      done <= qend && phase == 2'h3;
      // Sample late in the high time, clear of the sync delay
      if (qend && phase == 2'h2) begin
        bit_rx <= sda_in;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_start_edge:
    assert property ($rose(sda_oe) && !scl_oe && !$past(scl_oe) |-> op_q == OP_START)
    else $error("SDA fell under high SCL outside a START");
  a_stop_edge:
    assert property ($fell(sda_oe) && !scl_oe |-> op_q == OP_STOP && phase == 2'h2)
    else $error("SDA rose under high SCL outside a STOP");
  a_sda_steady:
    assert property (!scl_oe && !$past(scl_oe) && op_q inside {OP_WRITE, OP_READ} |-> $stable(sda_oe))
    else $error("SDA moved while SCL high during a data bit");
endmodule
`default_nettype wire

// File: verif/i2cm_dev_model.sv
// Memory-space device model on the two-wire bus
// Assumes resolved wire levels with pull-ups
`timescale 1ns/1ns
`default_nettype none
module i2cm_dev_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [2:0] address_select_pins,
  output logic            sda_oe
);
  // ****
  // Slave engine, memory space only
  // ****
  logic [7:0]  mem [0:32767];
  logic [7:0]  sh = 8'h00;
  logic [7:0]  ob = 8'h00;
  logic [14:0] ptr = 15'h0000;
  logic        act = 1'b0;
  logic        rd = 1'b0;
  int          n = 0;
  int          ph = 0;
  initial sda_oe = 1'b0;
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    rd = 1'b0;
    n = -1;
    ph = 0;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) if (act && n >= 0 && n < 8) sh = {sh[6:0], sda};
    else if (act && n == 8 && rd && sda) act = 1'b0;
  always @(negedge scl) if (!act) sda_oe = 1'b0; else begin
    n = n + 1;
    if (n == 8 && !rd) begin
      sda_oe = ph > 0 || (sh[7:4] == 4'ha && sh[3:1] == address_select_pins);
      if (ph == 0) rd = sh[0];
      if (ph == 1) ptr[14:8] = sh[6:0];
      if (ph == 2) ptr[7:0] = sh;
      if (ph == 3) begin
        mem[ptr] = sh;
        ptr = ptr + 1'b1;
      end
      if (!sda_oe) act = 1'b0;
      ph = (ph == 0 && sh[0]) ? 4 : (ph < 3 ? ph + 1 : 3);
    end else if (n == 8) sda_oe = 1'b0;
    else if (n == 9) begin
      n = 0;
      sda_oe = 1'b0;
      if (rd) begin
        ob = mem[ptr];
        ptr = ptr + 1'b1;
        sda_oe = !ob[7];
      end
    end else if (rd) sda_oe = !ob[7 - n]; // Pull low only
  end
endmodule
`default_nettype wire

// File: verif/i2cm_ctrl_tb_top.sv
// Bench for the two-wire host controller with a device model
// Assumes the model sits at select pins 5
`timescale 1ns/1ns
`default_nettype none
module i2cm_ctrl_tb_top;
  // ****
  // Harness
  // ****
  logic        clk = 0, rst = 1, cmd_valid = 0, cmd_rw = 0, cmd_hs = 0, wr_valid = 0;
  logic        cmd_use_addr = 1, cmd_stop = 1;
  logic [1:0]  cmd_space = 2'h0;
  logic [2:0]  cmd_dev_sel = 3'h5;
  logic [14:0] cmd_addr = 15'h0000, cur_addr;
  logic [7:0]  cmd_len = 8'h00, wr_data = 8'h00, rd_data;
  logic        cmd_ready, wr_ready, rd_valid, done, nack_err, bus_busy, hs_active;
  logic        scl_o, scl_oe, sda_o, sda_oe, dev_oe;
  wire logic   scl_i, sda_i;
  int          fails = 0, n_tests = 0;
  logic [7:0]  rq [$];
  assign scl_i = ~scl_oe;
  assign sda_i = ~(sda_oe | dev_oe);
  always #25 clk = ~clk;
  i2cm_ctrl u_i2cm_ctrl (.*);
  i2cm_dev_model u_i2cm_dev_model (.scl(scl_i), .sda(sda_i), .address_select_pins(3'h5), .sda_oe(dev_oe));
  task close_out;
    $display("tests %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [14:0] got, input logic [14:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic rw, ua, hs, input logic [2:0] sel, input logic [14:0] a,
            input logic [7:0] len, input logic [23:0] d);
    int   i;
    logic tk;
    rq = {};
    @(posedge clk);
    {cmd_valid, cmd_rw, cmd_use_addr, cmd_hs, cmd_dev_sel, cmd_addr, cmd_len} <= {1'b1, rw, ua, hs, sel, a, len};
    @(posedge clk);
    cmd_valid <= 0;
    wr_valid <= !rw && len != 0;
    wr_data <= d[23:16];
    for (i = 0; i < 40000; i++) begin
      @(negedge clk);
      if (rd_valid) rq.push_back(rd_data);
      if (done) break;
      tk = wr_valid && wr_ready;
      @(posedge clk);
      if (tk) begin
        d = d << 8;
        wr_data <= d[23:16];
        if (len == 1) wr_valid <= 0;
        len--;
      end
    end
    if (i == 40000) begin
      chk(15'h0001, 15'h0000);
      close_out;
    end
    // Aborted writes leave the stream offered: withdraw it
    @(posedge clk) wr_valid <= 0;
    @(negedge clk);
  endtask
  task t_wrap_write;
    xfer(0, 1, 0, 3'h5, 15'h7fff, 3, 24'ha53c96);
    chk(nack_err, 0);
    chk(cur_addr, 15'h0002);
    chk(u_i2cm_dev_model.mem[15'h7fff], 8'ha5);
    chk(u_i2cm_dev_model.mem[0], 8'h3c);
    chk(bus_busy, 0);
    chk({scl_o, sda_o}, 2'h0);
    $display("test wrap_write done");
  endtask
  task t_rand_read;
    xfer(1, 1, 1, 3'h5, 15'h7fff, 2, 0);
    chk(rq[0], 8'ha5);
    chk(rq[1], 8'h3c);
    chk(hs_active, 0);
    $display("test rand_read done");
  endtask
  task t_cur_read;
    xfer(1, 0, 0, 3'h5, 0, 1, 0);
    chk(rq[0], 8'h96);
    $display("test cur_read done");
  endtask
  task t_held_read;
    @(posedge clk) cmd_stop <= 0;
    xfer(0, 1, 1, 3'h5, 15'h7fff, 0, 0);
    chk(hs_active, 1);
    chk(bus_busy, 1);
    @(posedge clk) cmd_stop <= 1;
    xfer(1, 0, 0, 3'h5, 0, 3, 0);
    chk(rq[0], 8'ha5);
    chk(rq[2], 8'h96);
    chk(cur_addr, 15'h0002);
    chk(hs_active, 0);
    $display("test held_read done");
  endtask
  task t_bad_sel;
    xfer(0, 1, 0, 3'h2, 15'h0010, 1, 24'h110000);
    chk(nack_err, 1);
    // Model answers the memory space only, so a clock space select goes unacked
    @(posedge clk) cmd_space <= 2'h1;
    xfer(0, 1, 0, 3'h5, 15'h0020, 1, 24'h220000);
    chk(nack_err, 1);
    chk(cur_addr, 15'h0010);
    $display("test bad_sel done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_wrap_write;
    t_rand_read;
    t_cur_read;
    t_held_read;
    t_bad_sel;
    close_out;
  end
endmodule
`default_nettype wire
